// >>> hdl/vrss_sequencer.sv
/*
  Start-up sequencer, soft-start dac ramp, serial voltage-id receiver with
  telemetry, and master clock phase distributor for a two-output regulator.
  Assumes all pin inputs but telemetryCurrent are asynchronous and comparator events last at
  least three system clocks; the link clock is far slower than clk_sys.
*/
// Summary of operation
// RULE_01: three phases: master clock pulses go to phases one, two, three in turn.
// RULE_02: two phases: master clock pulses alternate between phase one and two.
// RULE_03: single phase: every master clock pulse goes to phase one only.
// RULE_04: master pulse when ramp reaches compensation level; ramp then reset.
// RULE_05: phase pulse starts on its clock, ends when its ripple hits window.
// RULE_06: light-load mode: low-side gate off once switch node reaches zero.
// RULE_07: channel with sense pin at supply level is excluded from sequencing.
// RULE_08: first-phase sense pin at supply level keeps that whole output off.
// RULE_09: ignore enable and serial inputs until supply passes reset threshold.
// RULE_10: host holds serial clock and data at boot code levels before enable.
// RULE_11: enable rising latches boot code; both outputs soft-start toward it.
// RULE_12: wait eight milliseconds sampling program pins before soft-start; code latches only the slew pin, light-load pin stays live.
// RULE_13: soft-start ramps dac code using the programmed slew setting.
// RULE_14: output good goes high when its soft-start ramp completes.
// RULE_15: host raises power-ok after both goods; commands accepted only then.
// RULE_16: after power-ok, host sends new codes as serial transactions.
// RULE_17: ramp to new code; completion indication only for upward changes.
// RULE_18: after a transition, clock current and voltage telemetry to host.
// RULE_19: delay counter resets when enable low or supply below threshold.
`timescale 1ns/1ns
module vrss_sequencer #(
  parameter int START_DELAY_CYC = vrss_pkg::START_DELAY_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // supply, enable, program pins
  input wire logic supplyAbovePor,
  input wire logic enablePin,
  input wire logic slewProgramPin,
  input wire logic lightLoadEmulation,
  // serial voltage-id bus
  input wire logic serialVidClock,
  input wire logic serialVidDataIn,
  output logic serialVidDataOut,
  output logic serialVidDataOe,
  input wire logic hostPowerOk,
  input wire logic [7:0] telemetryCurrent,
  // analog comparator events and channel straps
  input wire logic mainRampAtComp,
  input wire logic auxRampAtComp,
  input wire logic [5:0] rippleAtWindow,
  input wire logic [5:0] switchNodeZero,
  input wire logic [3:0] phaseCurrentSensePin,
  input wire logic [1:0] auxSensePin,
  // outputs
  output logic mainRampReset,
  output logic auxRampReset,
  output logic [5:0] pwmOut,
  output logic [5:0] lowSideGate,
  output logic [7:0] mainDacCode,
  output logic [7:0] auxDacCode,
  output logic mainOutputGood,
  output logic auxOutputGood,
  output logic voltageChangeDone
);
  localparam int DLY_W = $clog2(START_DELAY_CYC + 1);

  function automatic logic [2:0] phaseRun(input logic [3:0] off);
    logic stop;
    stop = 1'b0;
    phaseRun = 3'd0;
    for (int i = 0; i < 4; i++) begin
      if (off[i]) stop = 1'b1;
      if (!stop) phaseRun = phaseRun + 3'd1;
    end
  endfunction : phaseRun

  logic [vrss_pkg::SYNC_W-1:0] syncA_reg, syncB_reg;
  logic porS, enS, svcS, svdS, pokS, slewS, llS, mCmpS, aCmpS;
  logic [5:0] ripS, zeroS;
  logic [3:0] mOffS;
  logic [1:0] aOffS;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
    end else begin
      syncA_reg <= {supplyAbovePor, enablePin, serialVidClock, serialVidDataIn, hostPowerOk,
                    slewProgramPin, lightLoadEmulation, mainRampAtComp, auxRampAtComp,
                    rippleAtWindow, switchNodeZero, phaseCurrentSensePin, auxSensePin};
      syncB_reg <= syncA_reg;
    end
  end
  assign {porS, enS, svcS, svdS, pokS, slewS, llS, mCmpS, aCmpS, ripS, zeroS, mOffS, aOffS} =
    syncB_reg;

  logic svcDly_reg, mCmpDly_reg, aCmpDly_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      svcDly_reg <= 1'b0;
      mCmpDly_reg <= 1'b0;
      aCmpDly_reg <= 1'b0;
    end else begin
      svcDly_reg <= svcS;
      mCmpDly_reg <= mCmpS;
      aCmpDly_reg <= aCmpS;
    end
  end
  logic svcRise, svcFall, mMaster, aMaster;
  assign svcRise = svcS && !svcDly_reg;
  assign svcFall = !svcS && svcDly_reg;

  vrss_pkg::vrss_state_t state_reg;
  logic [DLY_W-1:0] delayCnt_reg;
  logic slewFast_reg, rampTick;
  logic [3:0] stepCnt_reg;
  logic [7:0] mainTgt_reg, auxTgt_reg;
  logic [2:0] mainCount;
  logic [1:0] auxCount;
  logic mainOn, auxOn, mainAt, auxAt, bothAt;
  assign mainCount = phaseRun(mOffS); // RULE_07
  assign auxCount = 2'(phaseRun({2'b11, aOffS}));
  assign mainOn = mainCount != 3'd0; // RULE_08
  assign auxOn = auxCount != 2'd0; // RULE_08
  assign mainAt = !mainOn || mainDacCode == mainTgt_reg;
  assign auxAt = !auxOn || auxDacCode == auxTgt_reg;
  assign bothAt = mainAt && auxAt;
  logic running;
  assign running = state_reg == vrss_pkg::ST_SOFT || state_reg == vrss_pkg::ST_GOOD ||
                   state_reg == vrss_pkg::ST_ACTIVE;
  assign mMaster = running && mainOn && mCmpS && !mCmpDly_reg; // RULE_04
  assign aMaster = running && auxOn && aCmpS && !aCmpDly_reg; // RULE_04

  // sequence state; supply loss or enable low restarts everything
  always_ff @(posedge clk_sys) begin
    if (rst || !porS) begin
      state_reg <= vrss_pkg::ST_WAIT_POR; // RULE_09
    end else if (state_reg != vrss_pkg::ST_WAIT_POR && !enS) begin
      state_reg <= vrss_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        vrss_pkg::ST_WAIT_POR: state_reg <= vrss_pkg::ST_IDLE;
        vrss_pkg::ST_IDLE: if (enS) state_reg <= vrss_pkg::ST_DELAY; // RULE_11
        vrss_pkg::ST_DELAY:
          if (delayCnt_reg == DLY_W'(START_DELAY_CYC - 1)) state_reg <= vrss_pkg::ST_SOFT;
        vrss_pkg::ST_SOFT: if (bothAt) state_reg <= vrss_pkg::ST_GOOD; // RULE_14
        vrss_pkg::ST_GOOD: if (pokS) state_reg <= vrss_pkg::ST_ACTIVE; // RULE_15
        vrss_pkg::ST_ACTIVE: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !porS || !enS || state_reg != vrss_pkg::ST_DELAY) begin
      delayCnt_reg <= '0; // RULE_19
    end else begin
      delayCnt_reg <= delayCnt_reg + DLY_W'(1); // RULE_12
    end
  end

  // program pin sampled through the delay, frozen afterwards
  always_ff @(posedge clk_sys) begin
    if (rst) slewFast_reg <= 1'b0;
    else if (state_reg == vrss_pkg::ST_DELAY) slewFast_reg <= slewS; // RULE_12
  end

  // one slew step per tick, same rate for soft-start and later changes
  assign rampTick = stepCnt_reg == (slewFast_reg ? 4'(vrss_pkg::STEP_FAST_CYC - 1) :
                                                  4'(vrss_pkg::STEP_SLOW_CYC - 1));
  always_ff @(posedge clk_sys) begin
    if (rst || !running || rampTick) stepCnt_reg <= '0;
    else stepCnt_reg <= stepCnt_reg + 4'd1; // RULE_13
  end

  // command receiver and telemetry shifter
  logic [3:0] rxCnt_reg;
  logic [8:0] rxShift_reg;
  logic cmdPend_reg, cmdUp_reg, telemOn_reg;
  logic [4:0] txCnt_reg;
  logic [15:0] txShift_reg;
  logic rxDone, cmdSel;
  logic [8:0] rxWord;
  assign rxWord = {rxShift_reg[7:0], svdS};
  assign rxDone = state_reg == vrss_pkg::ST_ACTIVE && pokS && svcRise && !telemOn_reg &&
                  rxCnt_reg == 4'(vrss_pkg::CMD_BITS - 1);
  assign cmdSel = rxWord[8];

  always_ff @(posedge clk_sys) begin
    if (rst || state_reg != vrss_pkg::ST_ACTIVE || !pokS || rxDone) begin
      rxCnt_reg <= '0; // RULE_15
      rxShift_reg <= '0;
    end else if (svcRise && !telemOn_reg) begin
      rxCnt_reg <= rxCnt_reg + 4'd1; // RULE_16
      rxShift_reg <= rxWord;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !enS || !porS) begin
      mainTgt_reg <= vrss_pkg::CODE_ZERO;
      auxTgt_reg <= vrss_pkg::CODE_ZERO;
    end else if (state_reg == vrss_pkg::ST_IDLE && enS) begin
      mainTgt_reg <= vrss_pkg::bootCode({svcS, svdS}); // RULE_11
      auxTgt_reg <= vrss_pkg::bootCode({svcS, svdS});
    end else if (rxDone && !cmdSel) begin
      mainTgt_reg <= rxWord[7:0];
    end else if (rxDone) begin
      auxTgt_reg <= rxWord[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !running) begin
      mainDacCode <= vrss_pkg::CODE_ZERO;
      auxDacCode <= vrss_pkg::CODE_ZERO;
    end else if (rampTick) begin
      if (mainOn && mainDacCode < mainTgt_reg) mainDacCode <= mainDacCode + 8'd1; // RULE_13
      else if (mainOn && mainDacCode > mainTgt_reg) mainDacCode <= mainDacCode - 8'd1;
      if (auxOn && auxDacCode < auxTgt_reg) auxDacCode <= auxDacCode + 8'd1; // RULE_13
      else if (auxOn && auxDacCode > auxTgt_reg) auxDacCode <= auxDacCode - 8'd1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !running) begin
      mainOutputGood <= 1'b0;
      auxOutputGood <= 1'b0;
    end else if (state_reg == vrss_pkg::ST_SOFT) begin
      mainOutputGood <= mainOn && mainAt; // RULE_14
      auxOutputGood <= auxOn && auxAt; // RULE_14
    end
  end

  // pending change: done pulse only if upward, then telemetry
  always_ff @(posedge clk_sys) begin
    if (rst || state_reg != vrss_pkg::ST_ACTIVE) begin
      cmdPend_reg <= 1'b0;
      cmdUp_reg <= 1'b0;
      voltageChangeDone <= 1'b0;
    end else if (rxDone) begin
      cmdPend_reg <= 1'b1;
      cmdUp_reg <= cmdSel ? rxWord[7:0] > auxDacCode : rxWord[7:0] > mainDacCode;
      voltageChangeDone <= 1'b0;
    end else begin
      voltageChangeDone <= cmdPend_reg && bothAt && cmdUp_reg; // RULE_17
      if (cmdPend_reg && bothAt) cmdPend_reg <= 1'b0;
    end
  end

  // telemetry driven on falling link clock edges; host samples on rising
  always_ff @(posedge clk_sys) begin
    if (rst || state_reg != vrss_pkg::ST_ACTIVE) begin
      telemOn_reg <= 1'b0;
      txCnt_reg <= '0;
      txShift_reg <= '0;
      serialVidDataOut <= 1'b0;
      serialVidDataOe <= 1'b0;
    end else if (cmdPend_reg && bothAt && !rxDone) begin
      telemOn_reg <= 1'b1; // RULE_18
      txCnt_reg <= '0;
      txShift_reg <= {telemetryCurrent, mainDacCode};
    end else if (telemOn_reg && svcFall) begin
      if (txCnt_reg == 5'(vrss_pkg::TELEM_BITS)) begin
        telemOn_reg <= 1'b0;
        serialVidDataOe <= 1'b0;
      end else begin
        serialVidDataOut <= txShift_reg[15]; // RULE_18
        serialVidDataOe <= 1'b1;
        txShift_reg <= {txShift_reg[14:0], 1'b0};
        txCnt_reg <= txCnt_reg + 5'd1;
      end
    end
  end

  // master clock rotation over enabled phases
  logic [1:0] mainPtr_reg;
  logic auxPtr_reg;
  logic [5:0] phaseClk_reg;
  always_ff @(posedge clk_sys) begin
    if (rst || !running) begin
      mainPtr_reg <= '0;
      auxPtr_reg <= 1'b0;
      phaseClk_reg <= '0;
      mainRampReset <= 1'b0;
      auxRampReset <= 1'b0;
    end else begin
      mainRampReset <= mMaster; // RULE_04
      auxRampReset <= aMaster;
      phaseClk_reg <= '0;
      if (mMaster) begin
        phaseClk_reg[mainPtr_reg] <= 1'b1; // RULE_01 RULE_02 RULE_03
        mainPtr_reg <= (3'(mainPtr_reg) + 3'd1 >= mainCount) ? 2'd0 : mainPtr_reg + 2'd1;
      end
      if (aMaster) begin
        phaseClk_reg[vrss_pkg::MAIN_PH + int'(auxPtr_reg)] <= 1'b1; // RULE_02 RULE_03
        auxPtr_reg <= (auxCount == 2'd2) ? !auxPtr_reg : 1'b0;
      end
    end
  end

  logic [5:0] zeroHit_reg;
  for (genvar i = 0; i < vrss_pkg::ALL_PH; i++) begin : g_phase
    // a strap change while running must not leave a pulse on a dead phase
    logic chanOn;
    assign chanOn = i < vrss_pkg::MAIN_PH ? 3'(i) < mainCount :
                                           2'(i - vrss_pkg::MAIN_PH) < auxCount;
    always_ff @(posedge clk_sys) begin
      if (rst || !running) begin
        pwmOut[i] <= 1'b0;
        lowSideGate[i] <= 1'b0;
        zeroHit_reg[i] <= 1'b0;
      end else begin
        if (!chanOn) pwmOut[i] <= 1'b0; // RULE_07 RULE_08
        else if (phaseClk_reg[i]) pwmOut[i] <= 1'b1; // RULE_05
        else if (ripS[i]) pwmOut[i] <= 1'b0; // RULE_05
        if (phaseClk_reg[i]) zeroHit_reg[i] <= 1'b0;
        else if (llS && zeroS[i] && lowSideGate[i]) zeroHit_reg[i] <= 1'b1; // RULE_06
        lowSideGate[i] <= chanOn && !phaseClk_reg[i] && !pwmOut[i] && !(llS && zeroS[i]) &&
                          !zeroHit_reg[i];
      end
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_por_holds_off: assert property (!porS |=> state_reg == vrss_pkg::ST_WAIT_POR) // RULE_09
    else $error("sequencer left wait state without supply");
  a_delay_full_count: assert property ($rose(state_reg == vrss_pkg::ST_SOFT) |->
    $past(delayCnt_reg) == DLY_W'(START_DELAY_CYC - 1)) // RULE_12
    else $error("soft-start began before full delay");
  a_master_reset: assert property (mMaster |=> mainRampReset) // RULE_04
    else $error("ramp reset missing after master pulse");
  a_three_phase_turn: assert property (mMaster && mainCount == 3'd3 && mainPtr_reg == 2'd2
    |=> phaseClk_reg[3:0] == 4'b0100 && mainPtr_reg == 2'd0) // RULE_01
    else $error("three-phase rotation wrong");
  a_two_phase_alt: assert property (mMaster && mainCount == 3'd2 && mainPtr_reg == 2'd1
    |=> phaseClk_reg[3:0] == 4'b0010 && mainPtr_reg == 2'd0) // RULE_02
    else $error("two-phase alternation wrong");
  a_single_phase: assert property (mMaster && mainCount == 3'd1 |=>
    phaseClk_reg[3:0] == 4'b0001) // RULE_03
    else $error("single-phase clock not on phase one");
  a_pulse_ends: assert property (pwmOut[0] && ripS[0] && !phaseClk_reg[0] |=> !pwmOut[0])
    // RULE_05
    else $error("pulse not ended at window level");
  a_emulation_off: assert property (llS && zeroS[1] |=> !lowSideGate[1]) // RULE_06
    else $error("low-side gate on past zero crossing");
  a_output_off: assert property (!mainOn [*2] |-> pwmOut[3:0] == 4'b0000) // RULE_08
    else $error("disabled output still switching");
  a_good_at_end: assert property ($rose(mainOutputGood) |-> $past(mainAt)) // RULE_14
    else $error("good raised before ramp end");
  a_done_upward: assert property (voltageChangeDone |-> $past(cmdUp_reg)) // RULE_17
    else $error("completion flagged for downward change");
endmodule : vrss_sequencer

// >>> inc/vrss_pkg.sv
/*
  Constants, timing counts, boot code table and state type for the
  regulator start-up and phase sequencer. Assumes a 50 ns system clock.
*/
package vrss_pkg;
  localparam int CLK_NS = 50;
  localparam int START_DELAY_NS = 8_000_000;
  localparam int START_DELAY_CYC = START_DELAY_NS / CLK_NS;
  // dac step in microvolts, slew rates in mV/us
  localparam int STEP_UV = 6250;
  localparam int SLEW_FAST_MV_US = 20;
  localparam int SLEW_SLOW_MV_US = 10;
  localparam int STEP_FAST_CYC = STEP_UV / SLEW_FAST_MV_US / CLK_NS;
  localparam int STEP_SLOW_CYC = STEP_UV / SLEW_SLOW_MV_US / CLK_NS;
  localparam int MAIN_PH = 4;
  localparam int AUX_PH = 2;
  localparam int ALL_PH = MAIN_PH + AUX_PH;
  localparam int CODE_W = 8;
  localparam int CMD_BITS = CODE_W + 1;
  localparam int TELEM_BITS = 2 * CODE_W;
  localparam int SYNC_W = 27;
  // boot codes selected by {clock, data} pin levels
  localparam logic [7:0] BOOT_CODE_0 = 8'h40;
  localparam logic [7:0] BOOT_CODE_1 = 8'h60;
  localparam logic [7:0] BOOT_CODE_2 = 8'h80;
  localparam logic [7:0] BOOT_CODE_3 = 8'hA0;
  localparam logic [7:0] CODE_ZERO = 8'h00;

  typedef enum logic [2:0] {ST_WAIT_POR, ST_IDLE, ST_DELAY, ST_SOFT, ST_GOOD, ST_ACTIVE}
    vrss_state_t;

  function automatic logic [7:0] bootCode(input logic [1:0] sel);
    unique case (sel)
      2'b00: bootCode = BOOT_CODE_0;
      2'b01: bootCode = BOOT_CODE_1;
      2'b10: bootCode = BOOT_CODE_2;
      2'b11: bootCode = BOOT_CODE_3;
    endcase
  endfunction : bootCode
endpackage : vrss_pkg

// >>> verification/vrss_host_model.sv
/*
  Host model on the serial voltage-id link: boot levels, power-ok, command
  and telemetry frames. Assumes the bench resolves the shared data wire.
*/
`timescale 1ns/1ns
module vrss_host_model (
  // link pins
  output logic serialVidClock,
  output logic hostData,
  output logic hostOe,
  input wire logic vidWire,
  // status
  input wire logic mainOutputGood,
  input wire logic auxOutputGood,
  output logic hostPowerOk
);
  localparam int HALF_NS = 200;
  initial begin
    serialVidClock = 1'b1;
    hostData = 1'b1;
    hostOe = 1'b1;
    hostPowerOk = 1'b0;
  end
  task automatic bootLevels(input logic [1:0] sel);
    hostOe = 1'b1;
    serialVidClock = sel[1];
    hostData = sel[0];
  endtask : bootLevels
  task automatic setOk(input logic ok);
    int w;
    w = 0;
    while (ok && !(mainOutputGood && auxOutputGood) && w < 5000) begin
      #(HALF_NS);
      w++;
    end
    hostPowerOk = ok && mainOutputGood === 1'b1 && auxOutputGood === 1'b1;
  endtask : setOk
  // offset keeps link edges away from the system clock edges
  task automatic sendCmd(input logic [8:0] word);
    #13;
    hostOe = 1'b1;
    for (int i = 8; i >= 0; i--) begin
      serialVidClock = 1'b0;
      hostData = word[i];
      #(HALF_NS);
      serialVidClock = 1'b1;
      #(HALF_NS);
    end
    hostData = ~hostData;
  endtask : sendCmd
  // closing falling edge lets the device release the line; the clock then
  // parks low so no stray rising edge lands in the command receiver
  task automatic readTel(output logic [15:0] word);
    #13;
    hostOe = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serialVidClock = 1'b0;
      #(HALF_NS);
      serialVidClock = 1'b1;
      word[i] = vidWire;
      #(HALF_NS);
    end
    serialVidClock = 1'b0;
    #(HALF_NS);
    hostOe = 1'b1;
  endtask : readTel
endmodule : vrss_host_model

// >>> verification/vrss_sequencer_tb_top.sv
/*
  Self-checking bench: start-up timing, phase distribution, serial commands
  and telemetry against an integer model. Assumes the host model file.
*/
`timescale 1ns/1ns
module vrss_sequencer_tb_top;
  localparam int DLY = 200;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic supplyAbovePor = 1'b0;
  logic enablePin = 1'b0;
  logic slewProgramPin = 1'b0;
  logic lightLoadEmulation = 1'b0;
  logic [7:0] telemetryCurrent = 8'h00;
  logic mainRampAtComp = 1'b0;
  logic auxRampAtComp = 1'b0;
  logic [5:0] rippleAtWindow = 6'h00;
  logic [5:0] switchNodeZero = 6'h00;
  logic [3:0] phaseCurrentSensePin = 4'h0;
  logic [1:0] auxSensePin = 2'h0;
  logic serialVidClock, hostData, hostOe, hostPowerOk, vidWire;
  logic idleBit = 1'b0;
  logic serialVidDataOut, serialVidDataOe, mainRampReset, auxRampReset;
  logic [5:0] pwmOut, lowSideGate;
  logic [7:0] mainDacCode, auxDacCode, mT, aT, cur;
  logic mainOutputGood, auxOutputGood, voltageChangeDone;
  int n_fail = 0;
  int n_tests = 0;
  int nDone = 0;
  // expected telemetry words, pushed per command and popped per readout
  logic [15:0] expTel[$];
  logic [31:0] seed = 32'hab4a_dfc6;

  always #25 clk_sys = ~clk_sys;
  // released data wire: no pull, so it toggles rather than hold a value
  always @(posedge clk_sys) idleBit <= ~idleBit;
  always @(posedge clk_sys) if (voltageChangeDone === 1'b1) nDone++;
  assign vidWire = (serialVidDataOe === 1'b1) ? serialVidDataOut : (hostOe ? hostData : idleBit);

  vrss_sequencer #(.START_DELAY_CYC(DLY)) dut_u (
    .clk_sys, .rst, .supplyAbovePor, .enablePin, .slewProgramPin, .lightLoadEmulation,
    .serialVidClock, .serialVidDataIn(vidWire), .serialVidDataOut, .serialVidDataOe,
    .hostPowerOk, .telemetryCurrent, .mainRampAtComp, .auxRampAtComp, .rippleAtWindow,
    .switchNodeZero, .phaseCurrentSensePin, .auxSensePin, .mainRampReset, .auxRampReset,
    .pwmOut, .lowSideGate, .mainDacCode, .auxDacCode, .mainOutputGood, .auxOutputGood,
    .voltageChangeDone
  );
  vrss_host_model host_u (
    .serialVidClock, .hostData, .hostOe, .vidWire, .mainOutputGood, .auxOutputGood,
    .hostPowerOk
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick
  task automatic chkV(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkV
  task automatic chkT(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chkT
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic startUp(input int c, output logic [7:0] boot);
    int w;
    int st;
    boot = 8'h40 + 8'(c) * 8'h20;
    st = c[0] ? vrss_pkg::STEP_FAST_CYC : vrss_pkg::STEP_SLOW_CYC;
    rst = 1'b1;
    supplyAbovePor = 1'b0;
    enablePin = 1'b1;
    slewProgramPin = c[0];
    phaseCurrentSensePin = 4'(8'h0f << (4 - c));
    auxSensePin = c[0] ? 2'b10 : 2'b00;
    lightLoadEmulation = (c == 2);
    host_u.bootLevels(2'(c));
    host_u.setOk(1'b0);
    tick(4);
    rst = 1'b0;
    tick(50);
    chkV({mainDacCode, auxDacCode}, 16'h0000);
    chkV(16'({mainOutputGood, auxOutputGood}), 16'h0000);
    supplyAbovePor = 1'b1;
    if (c == 1) begin
      tick(100);
      enablePin = 1'b0;
      tick(10);
      enablePin = 1'b1;
    end
    w = 0;
    while (mainDacCode === 8'h00 && w < 2000) begin
      tick(1);
      w++;
    end
    chkT(w, DLY, DLY + st + 10);
    w = 0;
    while (mainDacCode !== 8'h02 && w < 100) begin
      tick(1);
      w++;
    end
    chkT(w, st, st);
    while (!(mainOutputGood === 1'b1 && auxOutputGood === 1'b1) && w < 3000) begin
      tick(1);
      w++;
    end
    chkV({mainDacCode, auxDacCode}, {boot, boot});
    chkV(16'({mainOutputGood, auxOutputGood}), 16'h0003);
  endtask : startUp

  task automatic phaseRun(input int b, input int n);
    int w;
    int e;
    for (int k = 0; k < 2 * n; k++) begin
      e = b + k % n;
      if (b == 0) mainRampAtComp = 1'b1;
      else auxRampAtComp = 1'b1;
      w = 0;
      while ((b == 0 ? mainRampReset : auxRampReset) !== 1'b1 && w < 20) begin
        tick(1);
        w++;
      end
      chkT(w, 1, 6);
      w = 0;
      while (pwmOut[e] !== 1'b1 && w < 20) begin
        tick(1);
        w++;
      end
      chkV(16'(pwmOut), 16'(6'h01 << e));
      mainRampAtComp = 1'b0;
      auxRampAtComp = 1'b0;
      rippleAtWindow[e] = 1'b1;
      w = 0;
      while (pwmOut[e] !== 1'b0 && w < 20) begin
        tick(1);
        w++;
      end
      chkT(w, 1, 6);
      tick(2);
      chkV(16'(lowSideGate[e]), 16'h0001);
      switchNodeZero[e] = 1'b1;
      tick(5);
      chkV(16'(lowSideGate[e]), 16'(!lightLoadEmulation));
      switchNodeZero = 6'h00;
      rippleAtWindow = 6'h00;
      tick(4);
    end
  endtask : phaseRun

  task automatic doCmd(input logic [8:0] cw, input int up);
    int w;
    int d0;
    logic [15:0] tel;
    d0 = nDone;
    expTel.push_back({cur, mT});
    host_u.sendCmd(cw);
    w = 0;
    while ((mainDacCode !== mT || auxDacCode !== aT) && w < 2000) begin
      tick(1);
      w++;
    end
    chkV({mainDacCode, auxDacCode}, {mT, aT});
    tick(4);
    chkT(nDone - d0, up, up);
    host_u.readTel(tel);
    chkV(tel, expTel.pop_front());
    tick(2);
  endtask : doCmd

  initial begin : main_seq
    logic [7:0] boot;
    #2;
    for (int c = 0; c < 4; c++) begin
      startUp(c, boot);
      phaseRun(0, 4 - c);
      phaseRun(4, c[0] ? 1 : 2);
      cur = 8'(rnd());
      telemetryCurrent = cur;
      // command before power-ok must leave the dac alone
      host_u.sendCmd({1'b0, boot + 8'h10});
      tick(20);
      chkV(16'(mainDacCode), 16'(boot));
      host_u.setOk(1'b1);
      tick(4);
      mT = boot + 8'(rnd() % 8) + 8'h01;
      aT = boot;
      doCmd({1'b0, mT}, 1);
      aT = boot - 8'(rnd() % 8) - 8'h01;
      doCmd({1'b1, aT}, 0);
    end
    rst = 1'b1;
    phaseCurrentSensePin = 4'h1;
    host_u.setOk(1'b0);
    tick(4);
    rst = 1'b0;
    tick(DLY + 1000);
    mainRampAtComp = 1'b1;
    tick(10);
    mainRampAtComp = 1'b0;
    tick(10);
    chkV(16'({pwmOut[3:0], lowSideGate[3:0]}), 16'h0000);
    close_out();
  end

  initial begin : watchdog
    #(2_000_000);
    n_fail++;
    close_out();
  end
endmodule : vrss_sequencer_tb_top
